// [hw/gdc_params.svh]
// constants for the gate driver configuration and status register bank
// assumes a 125 MHz register clock and 8-bit register data
`ifndef GDC_PARAMS_SVH
`define GDC_PARAMS_SVH

// ************************************************************
// register addresses on the plain register port
// ************************************************************
`define GDC_ADDR_W 4
`define GDC_ADDR_OCREF 4'h0
`define GDC_ADDR_TIMING 4'h1
`define GDC_ADDR_STATUS 4'h2
`define GDC_ADDR_IRQ_EN 4'h3
`define GDC_ADDR_IRQ_CLR 4'h4
`define GDC_ADDR_IRQ_FLAG 4'h5

// ************************************************************
// field layout and reset values
// ************************************************************
`define GDC_DATA_W 8
`define GDC_TIMING_W 5
`define GDC_DEAD_MSB 4
`define GDC_DEAD_LSB 2
`define GDC_BLANK_MSB 1
`define GDC_BLANK_LSB 0
`define GDC_STAT_BUCK_OC_WARN 5
`define GDC_STAT_INPUT_OV_FAULT 4
`define GDC_RESET_BYTE 8'h00
`define GDC_RESET_TIMING 5'h00

// ************************************************************
// timing and analog mapping
// ************************************************************
`define GDC_CLK_PERIOD_NS 8
`define GDC_DEAD_MAX_NS 2000
`define GDC_DEAD_STEP_NS 250
`define GDC_BLANK_MAX_NS 4000
`define GDC_BLANK_CNT_W 9
`define GDC_DEAD_CNT_W 8
`define GDC_DAC_MIN_UV 991000
`define GDC_DAC_MAX_UV 4503000
`define GDC_DAC_FULL_CODE 255

`endif

// [hw/gdc_pkg.sv]
// types and decode functions for the gate driver register bank
// assumes gdc_params.svh is on the include path
`include "gdc_params.svh"

package gdc_pkg;

   // ************************************************************
   // types
   // ************************************************************
   typedef logic [`GDC_DATA_W-1:0] gdc_byte_t;
   typedef logic [`GDC_BLANK_CNT_W-1:0] gdc_blank_cnt_t;
   typedef logic [`GDC_DEAD_CNT_W-1:0] gdc_dead_cnt_t;
   typedef enum logic {GDC_IDLE, GDC_BLANK} gdc_blank_state_t;

   // ************************************************************
   // decode functions
   // ************************************************************
   // dead time: top code is shortest, one step less per code
   function automatic gdc_dead_cnt_t gdc_dead_cycles(input logic [2:0] sel);
      gdc_dead_cycles = gdc_dead_cnt_t'((`GDC_DEAD_MAX_NS - `GDC_DEAD_STEP_NS * int'(sel)) / `GDC_CLK_PERIOD_NS);
   endfunction : gdc_dead_cycles

   // blanking halves with each code step
   function automatic gdc_blank_cnt_t gdc_blank_cycles(input logic [1:0] sel);
      gdc_blank_cycles = gdc_blank_cnt_t'((`GDC_BLANK_MAX_NS >> sel) / `GDC_CLK_PERIOD_NS);
   endfunction : gdc_blank_cycles

   // linear dac map in microvolts, about 13.77 mV per code
   function automatic logic [31:0] gdc_dac_uv(input gdc_byte_t code);
      gdc_dac_uv = 32'(`GDC_DAC_MIN_UV +
         (int'(code) * (`GDC_DAC_MAX_UV - `GDC_DAC_MIN_UV)) / `GDC_DAC_FULL_CODE);
   endfunction : gdc_dac_uv

endpackage : gdc_pkg

// [hw/gdc_blank_if.sv]
// carrier between the register bank and its blanking timer
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface gdc_blank_if;
   import gdc_pkg::*;
   logic start;
   gdc_blank_cnt_t length;
   logic spike;
   logic blanking;
   logic trip;

   modport ctrl (output start, output length, output spike, input blanking, input trip);
   modport timer (input start, input length, input spike, output blanking, output trip);
endinterface : gdc_blank_if

// [hw/gdc_blank_timer.sv]
// blanking timer: hides current spikes after each switching event
// assumes start is a one-cycle pulse and spike is already synchronised
`timescale 1ns/1ps

module gdc_blank_timer
   import gdc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   gdc_blank_if.timer bus
);

   gdc_blank_state_t state;
   gdc_blank_cnt_t count;
   gdc_blank_state_t next_state;
   gdc_blank_cnt_t next_count;

   // ************************************************************
   // next state: a new switching event always restarts the window
   // ************************************************************
   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         GDC_IDLE: begin
            if (bus.start) begin
               next_state = GDC_BLANK;
               next_count = bus.length;
            end
         end
         GDC_BLANK: begin
            if (bus.start) begin
               next_count = bus.length;
            end else if (count <= gdc_blank_cnt_t'(1)) begin
               next_state = GDC_IDLE;
               next_count = '0;
            end else begin
               next_count = count - gdc_blank_cnt_t'(1);
            end
         end
      endcase
   end

   // state and counter
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= GDC_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // spikes inside the window, or on the switching edge itself, are ignored
   assign bus.blanking = (state == GDC_BLANK); // see RULE_07
   assign bus.trip = bus.spike && !bus.blanking && !bus.start; // see RULE_07

endmodule : gdc_blank_timer

// [hw/gdc_regs.sv]
// gate driver configuration and status register bank with blanking timer
// assumes a single 125 MHz clock, a plain strobe register port and
// supervisor comparator levels arriving asynchronously on pins
//
// Notes on behaviour
// RULE_01: reference code maps linearly onto dac voltage
// RULE_02: dead-time code 0 is 2000 ns, minus 250
// RULE_03: blanking codes give 4000, 2000, 1000, 500 ns
// RULE_04: timing bits 7..5 read zero, ignore writes
// RULE_05: buck overcurrent warning mirrors its comparator
// RULE_06: input overvoltage fault mirrors its comparator
// RULE_07: current spikes ignored during blanking window
// RULE_08: status read-only, mirrors comparators, resets zero
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "gdc_params.svh"

module gdc_regs
   import gdc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [`GDC_ADDR_W-1:0] I_ADDR,
   input wire logic [`GDC_DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [`GDC_DATA_W-1:0] O_RDATA,
   input wire logic [`GDC_DATA_W-1:0] I_SUPERVISOR,
   input wire logic I_SWITCH_EVENT,
   input wire logic I_CURRENT_SPIKE,
   output logic [`GDC_DATA_W-1:0] O_DAC_CODE,
   output logic [31:0] O_DAC_UV,
   output logic [`GDC_DEAD_CNT_W-1:0] O_DEAD_TIME_CYCLES,
   output logic [`GDC_BLANK_CNT_W-1:0] O_BLANK_CYCLES,
   output logic O_BLANKING,
   output logic O_OC_TRIP,
   output logic O_IRQ
);

   // ************************************************************
   // storage
   // ************************************************************
   gdc_byte_t overcurrent_threshold_code;
   logic [`GDC_TIMING_W-1:0] driver_timing_config;
   gdc_byte_t sup_meta;
   gdc_byte_t fault_status;
   gdc_byte_t status_prev;
   gdc_byte_t irq_enable;
   gdc_byte_t irq_flag;
   logic sw_meta;
   logic sw_sync;
   logic sw_prev;
   logic spike_meta;
   logic spike_sync;

   gdc_blank_if blank_bus ();

   // ************************************************************
   // address decode
   // ************************************************************
   wire logic wr_ocref = I_WR && (I_ADDR == `GDC_ADDR_OCREF);
   wire logic wr_timing = I_WR && (I_ADDR == `GDC_ADDR_TIMING);
   wire logic wr_irq_en = I_WR && (I_ADDR == `GDC_ADDR_IRQ_EN);
   wire logic wr_irq_clr = I_WR && (I_ADDR == `GDC_ADDR_IRQ_CLR);
   wire logic [2:0] dead_time_select = driver_timing_config[`GDC_DEAD_MSB:`GDC_DEAD_LSB];
   wire logic [1:0] blanking_time_select = driver_timing_config[`GDC_BLANK_MSB:`GDC_BLANK_LSB];
   wire gdc_byte_t status_rise = fault_status & ~status_prev;
   wire gdc_byte_t clr_mask = wr_irq_clr ? I_WDATA : `GDC_RESET_BYTE;
   wire logic sw_start = sw_sync && !sw_prev;

   // read selection; unmapped and write-only addresses read as zero
   wire gdc_byte_t timing_read = {3'h0, driver_timing_config}; // see RULE_04
   wire gdc_byte_t rd_mux =
      (I_ADDR == `GDC_ADDR_OCREF) ? overcurrent_threshold_code :
      (I_ADDR == `GDC_ADDR_TIMING) ? timing_read :
      (I_ADDR == `GDC_ADDR_STATUS) ? fault_status :
      (I_ADDR == `GDC_ADDR_IRQ_EN) ? irq_enable :
      (I_ADDR == `GDC_ADDR_IRQ_FLAG) ? irq_flag :
      `GDC_RESET_BYTE;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // status is the second flop of the comparator synchroniser, so it
   // lags the pins by two edges but never shows a metastable value
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sup_meta <= `GDC_RESET_BYTE;
         fault_status <= `GDC_RESET_BYTE; // see RULE_08
         status_prev <= `GDC_RESET_BYTE;
      end else begin
         sup_meta <= I_SUPERVISOR;
         fault_status <= sup_meta; // see RULE_05 see RULE_06 see RULE_08
         status_prev <= fault_status;
      end
   end

   // switching event and spike comparator synchronisers
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
         sw_prev <= 1'b0;
         spike_meta <= 1'b0;
         spike_sync <= 1'b0;
      end else begin
         sw_meta <= I_SWITCH_EVENT;
         sw_sync <= sw_meta;
         sw_prev <= sw_sync;
         spike_meta <= I_CURRENT_SPIKE;
         spike_sync <= spike_meta;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   // writes to the status address fall through: nothing decodes them
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         overcurrent_threshold_code <= `GDC_RESET_BYTE;
         driver_timing_config <= `GDC_RESET_TIMING;
         irq_enable <= `GDC_RESET_BYTE;
      end else begin
         if (wr_ocref) begin
            overcurrent_threshold_code <= I_WDATA;
         end
         if (wr_timing) begin
            driver_timing_config <= I_WDATA[`GDC_TIMING_W-1:0]; // see RULE_04
         end
         if (wr_irq_en) begin
            irq_enable <= I_WDATA;
         end
      end
   end

   // ************************************************************
   // sticky interrupt flags
   // ************************************************************
   // a rising status bit wins over a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < `GDC_DATA_W; gi++) begin : g_flag
         always_ff @(posedge I_CLK) begin
            if (I_RST) begin
               irq_flag[gi] <= 1'b0;
            end else if (status_rise[gi]) begin
               irq_flag[gi] <= 1'b1;
            end else if (clr_mask[gi]) begin
               irq_flag[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ************************************************************
   // blanking timer
   // ************************************************************
   assign blank_bus.start = sw_start;
   assign blank_bus.length = gdc_blank_cycles(blanking_time_select); // see RULE_03
   assign blank_bus.spike = spike_sync;

   gdc_blank_timer u_blank (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .bus (blank_bus.timer)
   );

   // ************************************************************
   // registered outputs
   // ************************************************************
   // decoded figures are registered so downstream analog control sees
   // clean levels; the cost is one extra cycle after a write
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_RDATA <= `GDC_RESET_BYTE;
         O_DAC_CODE <= `GDC_RESET_BYTE;
         O_DAC_UV <= 32'h0;
         O_DEAD_TIME_CYCLES <= '0;
         O_BLANK_CYCLES <= '0;
         O_BLANKING <= 1'b0;
         O_OC_TRIP <= 1'b0;
         O_IRQ <= 1'b0;
      end else begin
         O_RDATA <= I_RD ? rd_mux : `GDC_RESET_BYTE;
         O_DAC_CODE <= overcurrent_threshold_code;
         O_DAC_UV <= gdc_dac_uv(overcurrent_threshold_code); // see RULE_01
         O_DEAD_TIME_CYCLES <= gdc_dead_cycles(dead_time_select); // see RULE_02
         O_BLANK_CYCLES <= gdc_blank_cycles(blanking_time_select); // see RULE_03
         O_BLANKING <= blank_bus.blanking;
         O_OC_TRIP <= blank_bus.trip; // see RULE_07
         O_IRQ <= |(irq_flag & irq_enable);
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence ocref_write_s;
      wr_ocref;
   endsequence

   sequence timing_write_s;
      wr_timing;
   endsequence

   sequence switch_edge_s;
      sw_start;
   endsequence

   sequence quiet_reset_s;
      !I_RST [*3];
   endsequence

   // expected level worked out from the span here, not through the decode function
   dac_map_a: assert property (ocref_write_s |-> ##2 // see RULE_01
      (O_DAC_UV == 32'(991000 + (int'($past(I_WDATA, 2)) * 3512000) / 255)) &&
      (O_DAC_CODE == $past(I_WDATA, 2)))
      else $error("dac voltage does not follow written code");

   // skipped on the first edge after reset, where both outputs still hold zero
   dac_endpoints_a: assert property (!$past(I_RST) |-> // see RULE_01
      ((O_DAC_CODE != 8'h00) || (O_DAC_UV == 32'd991000)) &&
      ((O_DAC_CODE != 8'hFF) || (O_DAC_UV == 32'd4503000)))
      else $error("dac endpoint voltage wrong");

   dead_decode_a: assert property (timing_write_s ##1 !wr_timing |-> ##1 // see RULE_02
      O_DEAD_TIME_CYCLES == 8'((2000 - 250 * int'($past(I_WDATA[4:2], 2))) / 8))
      else $error("dead time count wrong");

   blank_decode_a: assert property (timing_write_s ##1 !wr_timing |-> ##1 // see RULE_03
      O_BLANK_CYCLES == 9'((4000 >> $past(I_WDATA[1:0], 2)) / 8))
      else $error("blanking count wrong");

   timing_upper_zero_a: assert property (I_RD && (I_ADDR == `GDC_ADDR_TIMING) |=> // see RULE_04
      O_RDATA[7:5] == 3'h0)
      else $error("timing upper bits not zero");

   buck_oc_mirror_a: assert property (quiet_reset_s ##0 I_RD && (I_ADDR == `GDC_ADDR_STATUS) |=> // see RULE_05
      O_RDATA[`GDC_STAT_BUCK_OC_WARN] == $past(I_SUPERVISOR[`GDC_STAT_BUCK_OC_WARN], 3))
      else $error("buck overcurrent warning not mirrored");

   input_ov_mirror_a: assert property (quiet_reset_s ##0 I_RD && (I_ADDR == `GDC_ADDR_STATUS) |=> // see RULE_06
      O_RDATA[`GDC_STAT_INPUT_OV_FAULT] == $past(I_SUPERVISOR[`GDC_STAT_INPUT_OV_FAULT], 3))
      else $error("input overvoltage fault not mirrored");

   blank_open_a: assert property (switch_edge_s |-> ##2 O_BLANKING [*2]) // see RULE_07
      else $error("blanking window did not open");

   blank_mask_a: assert property (O_BLANKING |-> !O_OC_TRIP) // see RULE_07
      else $error("trip during blanking window");

   status_ro_a: assert property (I_WR && (I_ADDR == `GDC_ADDR_STATUS) |=> // see RULE_08
      $stable(overcurrent_threshold_code) && $stable(driver_timing_config) && $stable(irq_enable))
      else $error("status write changed a register");

   irq_set_wins_a: assert property ((status_rise != 8'h00) |=>
      ((irq_flag & $past(status_rise)) == $past(status_rise)))
      else $error("interrupt event lost against clear");

endmodule : gdc_regs

// [tb/tb.sv]
// self-checking bench for the gate driver register bank
// assumes gdc_pkg is compiled first and gdc_params.svh is on the include path
`timescale 1ns/1ps
`include "gdc_params.svh"

module tb
   import gdc_pkg::*;
;
   // ************************************************************
   // clock, reset and design hookup
   // ************************************************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [`GDC_ADDR_W-1:0] addr = 4'h0;
   gdc_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   gdc_byte_t sup = 8'h00;
   logic sw_event = 1'b0;
   logic spike = 1'b0;
   gdc_byte_t rdata;
   gdc_byte_t dac_code;
   logic [31:0] dac_uv;
   gdc_dead_cnt_t dead_cycles;
   gdc_blank_cnt_t blank_cycles;
   logic blanking;
   logic oc_trip;
   logic irq;
   int n_fail = 0;
   int check_count = 0;
   integer seed = 73286;
   gdc_byte_t got;
   gdc_byte_t code;
   int len;
   int trips;

   // half period of 4 ns gives 125 MHz
   always #4 clk = ~clk;

   gdc_regs dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
      .O_RDATA(rdata), .I_SUPERVISOR(sup), .I_SWITCH_EVENT(sw_event), .I_CURRENT_SPIKE(spike),
      .O_DAC_CODE(dac_code), .O_DAC_UV(dac_uv), .O_DEAD_TIME_CYCLES(dead_cycles),
      .O_BLANK_CYCLES(blank_cycles), .O_BLANKING(blanking), .O_OC_TRIP(oc_trip), .O_IRQ(irq));

   // ************************************************************
   // expectations, bus tasks and reporting
   // ************************************************************
   // expected dac level in microvolts, exact span over 255 steps
   function automatic logic [31:0] exp_uv(input gdc_byte_t c);
      exp_uv = 32'(991000 + (int'(c) * 3512000) / 255);
   endfunction : exp_uv

   // dead time loses 250 ns per code step from 2000 ns
   function automatic logic [31:0] exp_dead(input logic [2:0] d);
      exp_dead = 32'((2000 - 250 * int'(d)) / 8);
   endfunction : exp_dead

   // blanking table written out rather than derived, to catch a wrong shift
   function automatic logic [31:0] exp_blank(input logic [1:0] b);
      case (b)
         2'b00: exp_blank = 32'd500;
         2'b01: exp_blank = 32'd250;
         2'b10: exp_blank = 32'd125;
         default: exp_blank = 32'd62;
      endcase
   endfunction : exp_blank

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   // one-cycle write strobe, nothing comes back
   task automatic reg_write(input logic [3:0] a, input gdc_byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_write

   // read data stands only in the cycle after the strobe edge
   task automatic reg_read(input logic [3:0] a, output gdc_byte_t d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_read

   // let synchronisers and registered outputs settle
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // the whole run is well under the 25000 cycles allowed here, so this only trips on a hang
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // every place reads zero after reset, unmapped and write-only included
      for (int a = 0; a < 16; a++) begin
         reg_read(4'(a), got);
         check("reset read", 32'h0, got);
      end
      // reference code: corners then random, readback and dac level
      for (int i = 0; i < 8; i++) begin
         code = (i == 0) ? 8'h00 : (i == 1) ? 8'h40 : (i == 2) ? 8'hFF : 8'($random(seed));
         reg_write(`GDC_ADDR_OCREF, code);
         settle(2);
         check("dac code", code, dac_code);
         check("dac uv", exp_uv(code), dac_uv);
         reg_read(`GDC_ADDR_OCREF, got);
         check("ocref read", code, got);
      end
      // every dead and blanking code, random upper bits that must not stick
      for (int t = 0; t < 32; t++) begin
         code = {3'($random(seed)) | 3'b001, 5'(t)};
         reg_write(`GDC_ADDR_TIMING, code);
         settle(2);
         check("dead cycles", exp_dead(code[4:2]), dead_cycles);
         check("blank cycles", exp_blank(code[1:0]), blank_cycles);
         reg_read(`GDC_ADDR_TIMING, got);
         check("timing read", {3'b000, code[4:0]}, got);
      end
      // status mirrors comparators both ways and ignores writes
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         sup <= (i == 0) ? 8'h30 : (i == 1) ? 8'h00 : 8'($random(seed));
         settle(4);
         reg_write(`GDC_ADDR_STATUS, ~sup);
         reg_read(`GDC_ADDR_STATUS, got);
         check("status warn bit", sup[5], got[5]);
         check("status ov bit", sup[4], got[4]);
         check("status read", sup, got);
      end
      // interrupts: clear leftovers, raise, mask, unmask, clear
      @(posedge clk);
      sup <= 8'h00;
      settle(4);
      reg_write(`GDC_ADDR_IRQ_CLR, 8'hFF);
      reg_write(`GDC_ADDR_IRQ_FLAG, 8'hFF);
      reg_read(`GDC_ADDR_IRQ_FLAG, got);
      check("flags cleared", 32'h0, got);
      reg_write(`GDC_ADDR_IRQ_EN, 8'h10);
      reg_read(`GDC_ADDR_IRQ_EN, got);
      check("enable read", 32'h10, got);
      @(posedge clk);
      sup <= 8'h30;
      settle(6);
      check("irq raised", 32'h1, irq);
      reg_read(`GDC_ADDR_IRQ_FLAG, got);
      check("flags set", 32'h30, got);
      reg_write(`GDC_ADDR_IRQ_EN, 8'h00);
      settle(2);
      check("irq masked", 32'h0, irq);
      reg_write(`GDC_ADDR_IRQ_EN, 8'h20);
      settle(2);
      check("irq unmasked", 32'h1, irq);
      reg_write(`GDC_ADDR_IRQ_CLR, 8'hFF);
      settle(2);
      check("irq cleared", 32'h0, irq);
      reg_read(`GDC_ADDR_IRQ_FLAG, got);
      check("flags after clear", 32'h0, got);
      reg_read(`GDC_ADDR_IRQ_CLR, got);
      check("clear reads zero", 32'h0, got);
      // a status rise and a clear land on the same edge: the rise must win
      @(posedge clk);
      sup <= 8'h31;
      @(posedge clk);
      reg_write(`GDC_ADDR_IRQ_CLR, 8'hFF);
      reg_read(`GDC_ADDR_IRQ_FLAG, got);
      check("set beats clear", 32'h01, got);
      // blanking window length per code, spikes inside hidden, outside trip
      for (int b = 0; b < 4; b++) begin
         reg_write(`GDC_ADDR_TIMING, {6'($random(seed)), 2'(b)});
         settle(2);
         @(posedge clk);
         sw_event <= 1'b1;
         len = 0;
         trips = 0;
         // look just after each edge so the first open cycle is not missed
         for (int w = 0; w < 10 && blanking !== 1'b1; w++) settle(1);
         while (blanking === 1'b1 && len < 600) begin
            if (len == 10) spike <= 1'b1;
            if (len == 40) spike <= 1'b0;
            if (oc_trip === 1'b1) trips++;
            len++;
            @(posedge clk);
            #1;
         end
         check("window length", exp_blank(2'(b)), len);
         check("trips in window", 32'h0, trips);
         sw_event <= 1'b0;
         spike <= 1'b1;
         settle(8);
         check("trip outside window", 32'h1, oc_trip);
         @(posedge clk);
         spike <= 1'b0;
         settle(6);
      end
      tally_and_finish();
   end
endmodule : tb
